// [logic/ext_irq_and_vector_select.sv]
// top: external interrupt control, vector table select and unlock window
`timescale 1ns/1ns
`default_nettype none
module ext_irq_and_vector_select
  import ext_irq_pkg::*;
#(
  parameter logic [1:0] BOOT_SIZE_DEFAULT = 2'h0
)
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire io_req_s     io_req,
  output logic [7:0]       io_rdata,
  input  wire logic        ext_irq_pin_a,
  input  wire logic        ext_irq_pin_b,
  input  wire logic        global_irq_enable,
  input  wire logic [1:0]  boot_size_setting,
  input  wire logic        app_side_boot_lock,
  input  wire logic        boot_side_boot_lock,
  input  wire logic        exec_in_boot,
  input  wire logic        instr_done,
  input  wire logic        ack_a,
  input  wire logic        ack_b,
  input  wire logic        wdt_clk_tick,
  input  wire logic        startup_done,
  input  wire logic        asleep,
  output logic             irq_a,
  output logic             irq_b,
  output logic             wake,
  output logic             vector_table_select,
  output logic [15:0]      vector_base
);

  // ************************************************************
  // register access
  // ************************************************************
  logic [7:0] mcu_control_ff;
  logic [7:0] general_interrupt_control_ff;
  logic [1:0] ext_flag_ff;
  logic [7:0] lo_addr;
  logic       addr_ok;
  logic       wr_mcu;
  logic       wr_general_interrupt_control;
  logic       wr_flag;

  // data space view is the I/O offset plus 0x20
  always_comb
  begin
    lo_addr = io_req.data_space ? io_req.addr - IO_DATA_OFFSET : io_req.addr;
    addr_ok = io_req.data_space ? (io_req.addr >= IO_DATA_OFFSET) : 1'b1;
  end

  assign wr_mcu  = io_req.wr & addr_ok & (lo_addr == MCU_CONTROL_OFS);
  assign wr_general_interrupt_control = io_req.wr & addr_ok & (lo_addr == GEN_IRQ_CTRL_OFS);
  assign wr_flag = io_req.wr & addr_ok & (lo_addr == EXT_FLAG_OFS);

  // sense fields: pin a bits 1:0, pin b bits 3:2, reset low level
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      mcu_control_ff <= MCU_CONTROL_RST;
    else if (wr_mcu)
      mcu_control_ff <= io_req.wdata;
  end

  // ************************************************************
  // vector select and unlock window
  // ************************************************************
  typedef enum logic [1:0] {
    UL_IDLE  = 2'b00,
    UL_OPEN  = 2'b01,
    UL_AFTER = 2'b11
  } unlock_e;

  unlock_e    ul_state_ff;
  logic [2:0] ul_cnt_ff;
  logic       unlock_set;
  logic       vsel_write;
  logic       blocked;

  assign unlock_set = wr_general_interrupt_control & io_req.wdata[UNLOCK_POS];
  // select write counts only inside the window, with unlock written zero
  assign vsel_write = wr_general_interrupt_control & ~io_req.wdata[UNLOCK_POS] & (ul_state_ff == UL_OPEN);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ul_state_ff <= UL_IDLE;
      ul_cnt_ff   <= 3'h0;
    end
    else
    begin
      case (ul_state_ff)
        UL_IDLE:
        begin
          if (unlock_set)
          begin
            ul_state_ff <= UL_OPEN;
            ul_cnt_ff   <= 3'h1;
          end
        end
        UL_OPEN:
        begin
          if (vsel_write)
            ul_state_ff <= UL_AFTER;
          else if (unlock_set)
            ul_cnt_ff <= 3'h1;
          else if (ul_cnt_ff == UNLOCK_CNT_MAX)
            ul_state_ff <= UL_IDLE; // unlock expires after four cycles
          else
            ul_cnt_ff <= ul_cnt_ff + 3'h1;
        end
        UL_AFTER:
        begin
          // a fresh unlock here opens a new window, else its bit would never clear
          if (unlock_set)
          begin
            ul_state_ff <= UL_OPEN;
            ul_cnt_ff   <= 3'h1;
          end
          // hold off until the instruction after the select write ends
          else if (instr_done)
            ul_state_ff <= UL_IDLE;
        end
        default: ul_state_ff <= UL_IDLE;
      endcase
    end
  end

  // blocked from the very cycle unlock is written; global enable left alone
  assign blocked = unlock_set | (ul_state_ff != UL_IDLE);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      general_interrupt_control_ff <= GEN_IRQ_CTRL_RST;
    else if (wr_general_interrupt_control)
    begin
      general_interrupt_control_ff[MASK_B_POS] <= io_req.wdata[MASK_B_POS];
      general_interrupt_control_ff[MASK_A_POS] <= io_req.wdata[MASK_A_POS];
      general_interrupt_control_ff[UNLOCK_POS] <= io_req.wdata[UNLOCK_POS] &
                                                  (ul_state_ff != UL_OPEN | unlock_set);
      if (vsel_write)
        general_interrupt_control_ff[VSEL_POS] <= io_req.wdata[VSEL_POS];
    end
    else if (ul_state_ff == UL_OPEN && ul_cnt_ff == UNLOCK_CNT_MAX)
      general_interrupt_control_ff[UNLOCK_POS] <= 1'b0;
  end

  // base address: flash start or boot section start set by boot size
  function automatic logic [15:0] boot_base(input logic [1:0] sz);
    case (sz)
      2'h0:    boot_base = 16'h0C00;
      2'h1:    boot_base = 16'h0E00;
      2'h2:    boot_base = 16'h0F00;
      default: boot_base = 16'h0F80;
    endcase
  endfunction

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      vector_table_select <= 1'b0;
      vector_base         <= APP_VECTOR_BASE;
    end
    else
    begin
      vector_table_select <= general_interrupt_control_ff[VSEL_POS];
      vector_base         <= general_interrupt_control_ff[VSEL_POS] ?
                             boot_base(boot_size_setting) : APP_VECTOR_BASE;
    end
  end

  // ************************************************************
  // pin sensing, flags and requests
  // ************************************************************
  logic [1:0] edge_evt;
  logic [1:0] level_req;
  logic [1:0] pins;
  logic [1:0] acks;
  logic [1:0] masks;
  logic       lock_block;

  assign pins  = {ext_irq_pin_b, ext_irq_pin_a}; // pin read even when driven as output
  assign acks  = {ack_b, ack_a};
  assign masks = {general_interrupt_control_ff[MASK_B_POS],
                  general_interrupt_control_ff[MASK_A_POS]};

  // locked section blocks vectors living in the other section
  assign lock_block = (general_interrupt_control_ff[VSEL_POS] & app_side_boot_lock & ~exec_in_boot)
                    | (~general_interrupt_control_ff[VSEL_POS] & boot_side_boot_lock & exec_in_boot);

  logic [1:0] req_ff;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_pin
      logic [1:0] sense;
      assign sense = mcu_control_ff[2*g+1 : 2*g];

      pin_sense pin_sense_inst (
        .clk       (clk),
        .resetn    (resetn),
        .pin       (pins[g]),
        .sense     (sense),
        .edge_evt  (edge_evt[g]),
        .level_req (level_req[g])
      );

      // set wins over the clear; level mode keeps it zero
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          ext_flag_ff[g] <= 1'b0;
        else if (sense == SENSE_LOW)
          ext_flag_ff[g] <= 1'b0;
        else if (edge_evt[g])
          ext_flag_ff[g] <= 1'b1;
        else if (acks[g] || (wr_flag && io_req.wdata[FLAG_A_POS+g]))
          ext_flag_ff[g] <= 1'b0;
      end

      // level pending or flag, masked, gated by global enable and blocking
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          req_ff[g] <= 1'b0;
        else
          req_ff[g] <= (ext_flag_ff[g] | level_req[g]) & masks[g] & global_irq_enable
                       & ~blocked & ~lock_block & ~(asleep & level_req[g] & ~startup_done);
      end
    end
  endgenerate

  assign irq_a = req_ff[0];
  assign irq_b = req_ff[1];

  // ************************************************************
  // wake from power-down
  // ************************************************************
  logic [1:0] wdt_samp_ff;
  logic       any_low;

  // source must keep the level until the instruction ends
  assign any_low = |(level_req & masks);

  // two watchdog samples of the level; wake then or when held to start-up end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      wdt_samp_ff <= 2'h0;
    else if (!asleep)
      wdt_samp_ff <= 2'h0;
    else if (wdt_clk_tick)
      wdt_samp_ff <= {wdt_samp_ff[0] & any_low, any_low};
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      wake <= 1'b0;
    else
      wake <= asleep & (wdt_samp_ff[1] | (any_low & startup_done));
  end

  // ************************************************************
  // read back
  // ************************************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      io_rdata <= 8'h00;
    else if (io_req.rd && addr_ok && lo_addr == MCU_CONTROL_OFS)
      io_rdata <= mcu_control_ff;
    else if (io_req.rd && addr_ok && lo_addr == GEN_IRQ_CTRL_OFS)
      io_rdata <= general_interrupt_control_ff;
    else if (io_req.rd && addr_ok && lo_addr == EXT_FLAG_OFS)
      io_rdata <= {ext_flag_ff, 6'h00};
    else
      io_rdata <= 8'h00;
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence unlock_wr_s;
    unlock_set && ul_state_ff == UL_IDLE;
  endsequence

  sequence no_vsel_s;
    !wr_general_interrupt_control [*4];
  endsequence

  unlock_expire_a: assert property (@(posedge clk) disable iff (!resetn)
    unlock_wr_s ##1 no_vsel_s |=> !general_interrupt_control_ff[UNLOCK_POS])
    else $error("unlock bit not cleared after four cycles");

  block_window_a: assert property (@(posedge clk) disable iff (!resetn)
    unlock_wr_s ##1 no_vsel_s |-> ##1 ul_state_ff == UL_IDLE)
    else $error("blocking not released after four cycles");

  block_now_a: assert property (@(posedge clk) disable iff (!resetn)
    unlock_set |=> !irq_a && !irq_b)
    else $error("request seen during unlock window");

  vsel_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    vsel_write |=> !general_interrupt_control_ff[UNLOCK_POS])
    else $error("unlock bit not cleared by select write");

  vsel_guard_a: assert property (@(posedge clk) disable iff (!resetn)
    wr_general_interrupt_control && ul_state_ff == UL_IDLE |=>
      $stable(general_interrupt_control_ff[VSEL_POS]))
    else $error("select changed without unlock");

  mask_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    !global_irq_enable || !masks[0] |=> !irq_a)
    else $error("request without enables");

  level_flag_a: assert property (@(posedge clk) disable iff (!resetn)
    mcu_control_ff[1:0] == SENSE_LOW |=> !ext_flag_ff[0])
    else $error("flag set in level mode");

  flag_set_a: assert property (@(posedge clk) disable iff (!resetn)
    edge_evt[0] && mcu_control_ff[1:0] != SENSE_LOW && !wr_mcu |=> ext_flag_ff[0])
    else $error("edge did not set flag");

  vbase_a: assert property (@(posedge clk) disable iff (!resetn)
    !general_interrupt_control_ff[VSEL_POS] |=> vector_base == APP_VECTOR_BASE)
    else $error("vector base wrong");

endmodule
`default_nettype wire

// [logic/ext_irq_pkg.sv]
// package: register map, field positions and timing counts of the external interrupt unit
package ext_irq_pkg;

  localparam logic [7:0] IO_DATA_OFFSET     = 8'h20;
  localparam logic [7:0] MCU_CONTROL_OFS    = 8'h35;
  localparam logic [7:0] GEN_IRQ_CTRL_OFS   = 8'h3B;
  localparam logic [7:0] EXT_FLAG_OFS       = 8'h3A;

  localparam logic [7:0] MCU_CONTROL_RST    = 8'h00;
  localparam logic [7:0] GEN_IRQ_CTRL_RST   = 8'h00;

  localparam int SENSE_A_POS  = 0;
  localparam int SENSE_B_POS  = 2;
  localparam int UNLOCK_POS   = 0;
  localparam int VSEL_POS     = 1;
  localparam int MASK_A_POS   = 6;
  localparam int MASK_B_POS   = 7;
  localparam int FLAG_A_POS   = 6;
  localparam int FLAG_B_POS   = 7;

  localparam logic [1:0] SENSE_LOW     = 2'h0;
  localparam logic [1:0] SENSE_CHANGE  = 2'h1;
  localparam logic [1:0] SENSE_FALL    = 2'h2;
  localparam logic [1:0] SENSE_RISE    = 2'h3;

  localparam int UNLOCK_CYCLES = 4;
  localparam logic [2:0] UNLOCK_CNT_MAX = 3'h4;

  localparam logic [15:0] APP_VECTOR_BASE = 16'h0000;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       data_space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } io_req_s;

endpackage

// [logic/pin_sense.sv]
// single pin sense unit: sampling, edge detect and level request
`timescale 1ns/1ns
`default_nettype none
module pin_sense
  import ext_irq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       pin,
  input  wire logic [1:0] sense,
  output var  logic       edge_evt,
  output var  logic       level_req
);

  logic samp_ff;
  logic prev_ff;

  // pin is sampled before edges are looked at
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      samp_ff <= 1'b1;
      prev_ff <= 1'b1;
    end
    else
    begin
      samp_ff <= pin;
      prev_ff <= samp_ff;
    end
  end

  // edge modes need the running clock
  always_comb
  begin
    case (sense)
      SENSE_CHANGE: edge_evt = samp_ff ^ prev_ff;
      SENSE_FALL:   edge_evt = prev_ff & ~samp_ff;
      SENSE_RISE:   edge_evt = ~prev_ff & samp_ff;
      default:      edge_evt = 1'b0;
    endcase
  end

  // low level taken straight from the pin, no clock needed
  assign level_req = (sense == SENSE_LOW) & ~pin;

endmodule
`default_nettype wire

// [tb/core_model.sv]
// partner: core model giving instruction completions and handler entries
`timescale 1ns/1ns
`default_nettype none
module core_model
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic irq_a,
  input  wire logic irq_b,
  input  wire logic ack_en,
  output var  logic instr_done,
  output var  logic ack_a,
  output var  logic ack_b
);
  // ************
  // core
  // ************
  logic [1:0] step_ff;
  // a completion every third cycle, so the unlock blocking must really wait for it
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      step_ff    <= 2'h0;
      instr_done <= 1'b0;
      ack_a      <= 1'b0;
      ack_b      <= 1'b0;
    end
    else
    begin
      step_ff    <= (step_ff == 2'h2) ? 2'h0 : step_ff + 2'h1;
      instr_done <= (step_ff == 2'h2);
      ack_a      <= ack_en && irq_a && !ack_a;
      ack_b      <= ack_en && irq_b && !ack_b;
    end
  end
endmodule
`default_nettype wire

// [tb/ext_irq_and_vector_select_bench.sv]
// bench: registers, sense modes, unlock window, boot locks and wake
`timescale 1ns/1ns
`default_nettype none
module ext_irq_and_vector_select_bench
  import ext_irq_pkg::*;
;
  // ************
  // bench
  // ************
  logic        clk;
  logic        resetn;
  io_req_s     io_req;
  logic [7:0]  io_rdata;
  logic [1:0]  pin;
  logic [1:0]  bsz;
  logic [1:0]  lock;
  logic [1:0]  irq;
  logic        gie, in_boot, done, ack_a, ack_b, ack_en;
  logic        wdt, su_done, asleep, wake, vsel;
  logic [15:0] vbase;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc_cnt = 0;

  ext_irq_and_vector_select ext_irq_and_vector_select_inst
  (
    .clk(clk), .resetn(resetn), .io_req(io_req), .io_rdata(io_rdata),
    .ext_irq_pin_a(pin[0]), .ext_irq_pin_b(pin[1]), .global_irq_enable(gie),
    .boot_size_setting(bsz), .app_side_boot_lock(lock[0]),
    .boot_side_boot_lock(lock[1]), .exec_in_boot(in_boot), .instr_done(done),
    .ack_a(ack_a), .ack_b(ack_b), .wdt_clk_tick(wdt), .startup_done(su_done),
    .asleep(asleep), .irq_a(irq[0]), .irq_b(irq[1]), .wake(wake),
    .vector_table_select(vsel), .vector_base(vbase)
  );
  core_model core_model_inst
  (
    .clk(clk), .resetn(resetn), .irq_a(irq[0]), .irq_b(irq[1]), .ack_en(ack_en),
    .instr_done(done), .ack_a(ack_a), .ack_b(ack_b)
  );

  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=0x%0h exp=0x%0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // data-space addresses have bit 6 set, I/O offsets never do
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    io_req <= '{1'b1, 1'b0, a[6], a, d};
    @(posedge clk);
    io_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    io_req <= '{1'b0, 1'b1, a[6], a, 8'h00};
    @(posedge clk);
    io_req <= '0;
    #1;
    chk({8'h00, io_rdata}, {8'h00, exp});
  endtask
  task automatic sel(input logic v);
    wr(GEN_IRQ_CTRL_OFS, 8'h41);
    wr(GEN_IRQ_CTRL_OFS, {6'h10, v, 1'b0});
  endtask
  task automatic tick;
    @(posedge clk);
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
  endtask

  task automatic t_regs;
    rd(8'h35, MCU_CONTROL_RST);
    rd(8'h5B, GEN_IRQ_CTRL_RST);
    rd(8'h10, 8'h00);
    chk(vbase, APP_VECTOR_BASE);
    wr(8'h55, 8'h0E);
    rd(8'h35, 8'h0E);
  endtask
  task automatic t_sense(input int s);
    logic [1:0] m;
    logic       f;
    logic       r;
    for (int k = 0; k < 4; k++)
    begin
      m = 2'(k);
      f = (m == SENSE_CHANGE) || (m == SENSE_FALL);
      r = (m == SENSE_CHANGE) || (m == SENSE_RISE);
      wr(MCU_CONTROL_OFS, 8'(m) << (2 * s));
      wr(GEN_IRQ_CTRL_OFS, 8'h40 << s);
      wr(EXT_FLAG_OFS, 8'hC0);
      @(posedge clk);
      pin[s] <= 1'b0;
      cyc(4);
      chk(irq[s], f || (m == SENSE_LOW));
      rd(EXT_FLAG_OFS, 8'(f) << (6 + s));
      wr(EXT_FLAG_OFS, 8'hC0);
      @(posedge clk);
      pin[s] <= 1'b1;
      cyc(4);
      chk(irq[s], r);
      rd(EXT_FLAG_OFS, 8'(r) << (6 + s));
      wr(EXT_FLAG_OFS, 8'hC0);
      cyc(3);
      chk(irq[s], 1'b0);
    end
  endtask
  task automatic t_gate;
    wr(MCU_CONTROL_OFS, {6'h00, SENSE_FALL});
    wr(GEN_IRQ_CTRL_OFS, 8'h40);
    @(posedge clk);
    pin[0] <= 1'b0;
    gie <= 1'b0;
    cyc(4);
    chk(irq[0], 1'b0);
    rd(EXT_FLAG_OFS, 8'h40);
    @(posedge clk);
    gie <= 1'b1;
    cyc(3);
    chk(irq[0], 1'b1);
    wr(GEN_IRQ_CTRL_OFS, 8'h00);
    cyc(3);
    chk(irq[0], 1'b0);
    wr(GEN_IRQ_CTRL_OFS, 8'h40);
    @(posedge clk);
    ack_en <= 1'b1;
    cyc(4);
    rd(EXT_FLAG_OFS, 8'h00);
    @(posedge clk);
    ack_en <= 1'b0;
    pin[0] <= 1'b1;
  endtask
  // pending request on pin a is kept throughout, so blocking shows on irq_a
  task automatic t_vsel;
    logic [15:0] base [4] = '{16'h0C00, 16'h0E00, 16'h0F00, 16'h0F80};
    @(posedge clk);
    pin[0] <= 1'b0;
    cyc(4);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      bsz <= 2'(k);
      sel(1'b1);
      cyc(1);
      chk(irq[0], 1'b0);
      chk(vsel, 1'b1);
      rd(GEN_IRQ_CTRL_OFS, 8'h42);
      chk(vbase, base[k]);
      cyc(8);
      chk(irq[0], 1'b1);
      sel(1'b0);
      cyc(2);
      chk(vbase, APP_VECTOR_BASE);
    end
    cyc(6);
    wr(GEN_IRQ_CTRL_OFS, 8'h41);
    cyc(2);
    chk(irq[0], 1'b0);
    cyc(6);
    chk(irq[0], 1'b1);
    wr(GEN_IRQ_CTRL_OFS, 8'h42);
    cyc(1);
    chk(vsel, 1'b0);
    rd(GEN_IRQ_CTRL_OFS, 8'h40);
  endtask
  task automatic t_lock;
    sel(1'b1);
    @(posedge clk);
    lock <= 2'b01;
    cyc(8);
    chk(irq[0], 1'b0);
    @(posedge clk);
    in_boot <= 1'b1;
    cyc(3);
    chk(irq[0], 1'b1);
    sel(1'b0);
    @(posedge clk);
    lock <= 2'b10;
    cyc(8);
    chk(irq[0], 1'b0);
    @(posedge clk);
    in_boot <= 1'b0;
    cyc(3);
    chk(irq[0], 1'b1);
    @(posedge clk);
    lock <= 2'b00;
  endtask
  // level gone before start-up ends: the part wakes but no request follows
  task automatic t_wake;
    wr(MCU_CONTROL_OFS, {6'h00, SENSE_LOW});
    @(posedge clk);
    pin[0] <= 1'b1;
    asleep <= 1'b1;
    su_done <= 1'b0;
    cyc(3);
    @(posedge clk);
    pin[0] <= 1'b0;
    tick();
    cyc(2);
    chk(wake, 1'b0);
    tick();
    cyc(2);
    chk(wake, 1'b1);
    @(posedge clk);
    pin[0] <= 1'b1;
    cyc(3);
    @(posedge clk);
    su_done <= 1'b1;
    cyc(4);
    chk(irq[0], 1'b0);
    chk(wake, 1'b1);
    // second wake path: no watchdog samples, level simply held to start-up end
    @(posedge clk);
    asleep <= 1'b0;
    cyc(2);
    chk(wake, 1'b0);
    @(posedge clk);
    asleep <= 1'b1;
    su_done <= 1'b0;
    pin[0] <= 1'b0;
    cyc(3);
    chk(wake, 1'b0);
    @(posedge clk);
    su_done <= 1'b1;
    cyc(2);
    chk(wake, 1'b1);
    chk(irq[0], 1'b1);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  initial
  begin
    resetn = 1'b0;
    io_req = '0;
    pin = 2'b11;
    gie = 1'b1;
    bsz = 2'h0;
    lock = 2'b00;
    in_boot = 1'b0;
    ack_en = 1'b0;
    wdt = 1'b0;
    su_done = 1'b1;
    asleep = 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_sense(0);
    t_sense(1);
    t_gate();
    t_vsel();
    t_lock();
    t_wake();
    complete_run();
  end
endmodule
`default_nettype wire
